// ### design/lcdrp_defines.vh
// Constants of the display driver's two-wire read port.
// Included by the read port only; holds definitions only.
`ifndef LCDRP_DEFINES_VH
`define LCDRP_DEFINES_VH

// Slave identifiers of the two register blocks.
`define LCDRP_ID_CTL 7'h38
`define LCDRP_ID_SEG 7'h39

// Number of registers in each block.
`define LCDRP_CTL_REGS 8'h04
`define LCDRP_SEG_REGS 8'h28

// Bits that exist in each register; the others read as zero.
`define LCDRP_MASK_CTL0 8'he3
`define LCDRP_MASK_CTL1 8'he7
`define LCDRP_MASK_CTL2 8'h0f
`define LCDRP_MASK_CTL3 8'hc1
`define LCDRP_MASK_SEG 8'h0f

// Depth of the buffer between register fetch and serial shifter.
`define LCDRP_BUF_DEPTH 2

`endif

// ### design/lcdrp_fifo2.v
// Small FIFO with valid and ready on both sides and a flush.
// Assumes one clock and a synchronous, active-low reset.
`timescale 1ns/1ps
module lcdrp_fifo2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  // Clock, reset and flush.
  input wire clk,
  input wire reset_n,
  input wire flush,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != FULL);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at DEPTH; a flush empties the buffer at once.
  always @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### design/lcdrp_read_port.v
// Two-wire slave read port of the segment display driver.
// Assumes a 40 MHz system clock and bus pins resolved outside as open drain.
//
// Overview of operation
// - A read is start, identifier, address, repeated start, identifier, bytes, stop.
// - The control block answers identifier 0111000 in both phases.
// - The display block answers identifier 0111001.
// - The slave acknowledges an accepted identifier and the address byte on the ninth clock; bytes written after the address are not.
// - The slave drives each read byte, bit seven first, on clocks one to eight.
// - The register address increases by one after each byte until stop.
// - Two register spaces exist: display memory and control settings.
// - Control addresses 00h-03h and display addresses 00h-27h are decoded.
`timescale 1ns/1ps
`include "lcdrp_defines.vh"
module lcdrp_read_port (
  // Clock and reset; reset comes from the host's port bit.
  input wire CLK_SYS,
  input wire RESET_N,
  // Serial clock pin, open drain for stretching.
  input wire SCL_I,
  output wire SCL_O,
  output reg SCL_OE,
  // Serial data pin, open drain.
  input wire SDA_I,
  output wire SDA_O,
  output reg SDA_OE,
  // Register load port from the driver's write side.
  input wire LOAD_EN,
  input wire LOAD_BLOCK,
  input wire [7:0] LOAD_ADDR,
  input wire [7:0] LOAD_DATA,
  // Bus state.
  output reg SELECTED
);
  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_ID = 10'h002;
  localparam [9:0] S_ACK_ID = 10'h004;
  localparam [9:0] S_ADDR = 10'h008;
  localparam [9:0] S_ACK_ADDR = 10'h010;
  localparam [9:0] S_WAIT = 10'h020;
  localparam [9:0] S_LOAD = 10'h040;
  localparam [9:0] S_TX = 10'h080;
  localparam [9:0] S_RX_ACK = 10'h100;
  localparam [9:0] S_IGNORE = 10'h200;

  reg scl_s1_reg, scl_s2_reg, scl_s3_reg;
  reg sda_s1_reg, sda_s2_reg, sda_s3_reg;
  reg [9:0] state_reg;
  reg [3:0] cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [7:0] addr_reg;
  reg [7:0] fetch_addr_reg;
  reg addr_valid_reg;
  reg block_reg;
  reg reading_reg;
  reg fetch_en_reg;
  reg ack_reg;
  reg [7:0] ctl_mem [0:3];
  reg [7:0] seg_mem [0:39];
  reg [7:0] fetch_data;
  reg [7:0] load_mask;
  integer i;

  wire start_det;
  wire stop_det;
  wire scl_rise;
  wire scl_fall;
  wire id_hit;
  wire wr_ok;
  wire rd_ok;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire buf_pop;
  wire buf_flush;

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

  // Both bus lines pass two flip-flops; the third only keeps the old level.
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      scl_s1_reg <= SCL_I;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= SDA_I;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  assign start_det = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
  assign stop_det = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
  assign scl_rise = scl_s2_reg && !scl_s3_reg;
  assign scl_fall = !scl_s2_reg && scl_s3_reg;

  // Identifier check on the eight received bits.
  assign id_hit = (shift_reg[7:1] == `LCDRP_ID_CTL) || (shift_reg[7:1] == `LCDRP_ID_SEG);
  assign wr_ok = id_hit && !shift_reg[0];
  assign rd_ok = id_hit && shift_reg[0] && addr_valid_reg && (shift_reg[1] == block_reg);

  // Register storage: control settings and display memory.
  always @* begin
    case (LOAD_ADDR)
      8'h00: load_mask = `LCDRP_MASK_CTL0;
      8'h01: load_mask = `LCDRP_MASK_CTL1;
      8'h02: load_mask = `LCDRP_MASK_CTL2;
      default: load_mask = `LCDRP_MASK_CTL3;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctl_mem[i] <= 8'h00;
      end
      for (i = 0; i < 40; i = i + 1) begin
        seg_mem[i] <= 8'h00;
      end
    end else if (LOAD_EN) begin
      if (!LOAD_BLOCK && LOAD_ADDR < `LCDRP_CTL_REGS) begin
        ctl_mem[LOAD_ADDR[1:0]] <= LOAD_DATA & load_mask;
      end else if (LOAD_BLOCK && LOAD_ADDR < `LCDRP_SEG_REGS) begin
        seg_mem[LOAD_ADDR[5:0]] <= LOAD_DATA & `LCDRP_MASK_SEG;
      end
    end
  end

  // Addresses outside a block read as zero.
  always @* begin
    fetch_data = 8'h00;
    if (!block_reg && fetch_addr_reg < `LCDRP_CTL_REGS) begin
      fetch_data = ctl_mem[fetch_addr_reg[1:0]];
    end else if (block_reg && fetch_addr_reg < `LCDRP_SEG_REGS) begin
      fetch_data = seg_mem[fetch_addr_reg[5:0]];
    end
  end

  // Read bytes are fetched ahead into the buffer.
  assign buf_flush = start_det || stop_det;
  assign buf_pop = (state_reg == S_LOAD) && buf_out_valid;

  lcdrp_fifo2 #(
    .WIDTH(8),
    .DEPTH(`LCDRP_BUF_DEPTH)
  ) u_buf (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .flush(buf_flush),
    .in_valid(fetch_en_reg),
    .in_ready(buf_in_ready),
    .in_data(fetch_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      fetch_addr_reg <= 8'h00;
      fetch_en_reg <= 1'b0;
    end else if (buf_flush) begin
      fetch_en_reg <= 1'b0;
    end else if (state_reg == S_ID && scl_fall && cnt_reg == 4'h8 && rd_ok) begin
      fetch_addr_reg <= addr_reg;
      fetch_en_reg <= 1'b1;
    end else if (state_reg == S_IGNORE) begin
      fetch_en_reg <= 1'b0;
    end else if (fetch_en_reg && buf_in_ready) begin
      fetch_addr_reg <= fetch_addr_reg + 8'h01;
    end
  end

  // Bus protocol sequencer.
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      addr_reg <= 8'h00;
      addr_valid_reg <= 1'b0;
      block_reg <= 1'b0;
      reading_reg <= 1'b0;
      ack_reg <= 1'b0;
      SDA_OE <= 1'b0;
      SCL_OE <= 1'b0;
      SELECTED <= 1'b0;
    end else if (start_det) begin
      state_reg <= S_ID;
      cnt_reg <= 4'h0;
      SDA_OE <= 1'b0;
      SCL_OE <= 1'b0;
    end else if (stop_det) begin
      state_reg <= S_IDLE;
      addr_valid_reg <= 1'b0;
      SDA_OE <= 1'b0;
      SCL_OE <= 1'b0;
      SELECTED <= 1'b0;
    end else begin
      case (state_reg)
        S_ID, S_ADDR: begin
          if (scl_rise && cnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (scl_fall && cnt_reg == 4'h8) begin
            cnt_reg <= 4'h0;
            if (state_reg == S_ADDR) begin
              addr_reg <= shift_reg;
              addr_valid_reg <= 1'b1;
              SDA_OE <= 1'b1;
              state_reg <= S_ACK_ADDR;
            end else if (wr_ok || rd_ok) begin
              block_reg <= shift_reg[1];
              reading_reg <= rd_ok;
              SELECTED <= 1'b1;
              SDA_OE <= 1'b1;
              state_reg <= S_ACK_ID;
            end else begin
              SELECTED <= 1'b0;
              state_reg <= S_IGNORE;
            end
          end
        end
        S_ACK_ID: begin
          if (scl_fall) begin
            SDA_OE <= 1'b0;
            if (reading_reg) begin
              SCL_OE <= 1'b1;
              state_reg <= S_LOAD;
            end else begin
              state_reg <= S_ADDR;
            end
          end
        end
        S_ACK_ADDR: begin
          if (scl_fall) begin
            SDA_OE <= 1'b0;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (scl_rise) begin
            state_reg <= S_IGNORE;
          end
        end
        S_LOAD: begin
          if (buf_out_valid) begin
            tx_reg <= buf_out_data;
            SDA_OE <= ~buf_out_data[7];
            cnt_reg <= 4'h0;
            state_reg <= S_TX;
          end
        end
        S_TX: begin
          // The clock is let go one cycle after the first bit is set up.
          SCL_OE <= 1'b0;
          if (scl_fall) begin
            cnt_reg <= cnt_reg + 4'h1;
            tx_reg <= {tx_reg[6:0], 1'b0};
            if (cnt_reg == 4'h7) begin
              SDA_OE <= 1'b0;
              state_reg <= S_RX_ACK;
            end else begin
              SDA_OE <= ~tx_reg[6];
            end
          end
        end
        S_RX_ACK: begin
          if (scl_rise) begin
            ack_reg <= ~sda_s2_reg;
          end
          if (scl_fall) begin
            if (ack_reg) begin
              SCL_OE <= 1'b1;
              state_reg <= S_LOAD;
            end else begin
              state_reg <= S_IGNORE;
            end
          end
        end
        S_IDLE, S_IGNORE: begin
          SDA_OE <= 1'b0;
        end
        default: begin
          state_reg <= S_IDLE;
          SDA_OE <= 1'b0;
          SCL_OE <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### bench/lcdrp_read_port_monitor.sv
// Concurrent checks on the pins of the two-wire read port.
// Assumes both bus wires are resolved outside with pull-ups.
`timescale 1ns/1ps
module lcdrp_monitor (
  // Clock and reset.
  input wire CLK_SYS,
  input wire RESET_N,
  // Bus pins.
  input wire SCL_I,
  input wire SCL_O,
  input wire SCL_OE,
  input wire SDA_I,
  input wire SDA_O,
  input wire SDA_OE,
  // Bus state.
  input wire SELECTED
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence stop_seen;
    $rose(SDA_I) && SCL_I && $past(SCL_I);
  endsequence
  chk_pins_low: assert property (!SDA_O && !SCL_O)
    else $error("pin drive value not low");
  chk_reset_quiet: assert property ($rose(RESET_N) |-> !SDA_OE && !SCL_OE && !SELECTED)
    else $error("outputs active after reset");
  chk_sda_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I)
    else $error("data drive changed while clock high");
  chk_stretch_low: assert property ($rose(SCL_OE) |-> !SCL_I)
    else $error("clock stretch began while clock high");
  chk_stretch_short: assert property (SCL_OE |-> ##[1:8] !SCL_OE)
    else $error("clock stretch too long");
  chk_sel_acked: assert property ($rose(SELECTED) |-> SDA_OE || $past(SDA_OE))
    else $error("selected without acknowledge");
  chk_stop_desel: assert property (stop_seen |-> ##[1:6] !SELECTED)
    else $error("still selected after stop");
  chk_stop_free: assert property (stop_seen |-> !SDA_OE)
    else $error("data held at stop");
  cover property ($rose(SELECTED));
  cover property ($rose(SCL_OE));
  cover property (SELECTED ##1 !SELECTED);
endmodule

bind lcdrp_read_port lcdrp_monitor i_lcdrp_monitor (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .SELECTED(SELECTED));

// ### bench/lcdrp_host_bfm.sv
// Behavioural two-wire bus master standing for the host controller.
// Assumes open-drain wires with pull-ups, resolved by the bench.
`timescale 1ns/1ps
module lcdrp_host_bfm (
  // System clock that paces every step.
  input wire clk,
  // Resolved wire levels.
  input wire scl,
  input wire sda,
  // Pull-down enables.
  output reg scl_dn,
  output reg sda_dn
);
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task wait_hi;
    integer n;
    begin
      n = 0;
      while (scl !== 1'b1 && n < 200) begin
        tick(1);
        n = n + 1;
      end
    end
  endtask
  task start_cond;
    begin
      tick(2);
      sda_dn = 1'b0;
      tick(2);
      scl_dn = 1'b0;
      wait_hi;
      tick(2);
      sda_dn = 1'b1;
      tick(2);
      scl_dn = 1'b1;
    end
  endtask
  task stop_cond;
    begin
      tick(2);
      sda_dn = 1'b1;
      tick(2);
      scl_dn = 1'b0;
      wait_hi;
      tick(2);
      sda_dn = 1'b0;
    end
  endtask
  task bit_x(input b, output r);
    begin
      tick(2);
      sda_dn = ~b;
      tick(2);
      scl_dn = 1'b0;
      wait_hi;
      r = sda;
      tick(4);
      scl_dn = 1'b1;
    end
  endtask
  task xfer(input [7:0] d, input rel, output [7:0] q, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(d[i], r);
        q[i] = r;
      end
      bit_x(rel, ack);
    end
  endtask
endmodule

// ### bench/lcdrp_read_port_tb.sv
// Self-checking bench of the two-wire read port.
// Assumes the host model drives the bus; both wires have pull-ups.
`timescale 1ns/1ps
module lcdrp_read_port_tb;
  reg clk_sys, reset_n, load_en, load_block;
  reg [7:0] load_addr, load_data;
  reg [7:0] exp [0:3];
  wire scl_o, scl_oe, sda_o, sda_oe, selected, scl_dn, sda_dn;
  wire scl = ~((scl_oe & ~scl_o) | scl_dn);
  wire sda = ~((sda_oe & ~sda_o) | sda_dn);
  integer error_cnt, checks_done, cycles;
  lcdrp_read_port i_lcdrp_read_port (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SCL_I(scl),
    .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .LOAD_EN(load_en), .LOAD_BLOCK(load_block), .LOAD_ADDR(load_addr),
    .LOAD_DATA(load_data), .SELECTED(selected));
  lcdrp_host_bfm i_lcdrp_host_bfm (.clk(clk_sys), .scl(scl), .sda(sda), .scl_dn(scl_dn),
    .sda_dn(sda_dn));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task chk(input [7:0] got, input [7:0] want, input [8*8-1:0] what);
    begin
      checks_done = checks_done + 1;
      if (got !== want) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s expected %h seen %h", what, want, got);
      end
    end
  endtask
  task load(input blk, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys) #1;
      load_en = 1'b1;
      load_block = blk;
      load_addr = a;
      load_data = d;
      @(posedge clk_sys) #1;
      load_en = 1'b0;
    end
  endtask
  task rd_seq(input [6:0] id, input [7:0] a, input integer n);
    integer k;
    reg [7:0] q;
    reg ack;
    begin
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({id, 1'b0}, 1'b1, q, ack);
      chk(ack, 8'h00, "id_ack");
      i_lcdrp_host_bfm.xfer(a, 1'b1, q, ack);
      chk(ack, 8'h00, "adr_ack");
      chk(selected, 8'h01, "sel");
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({id, 1'b1}, 1'b1, q, ack);
      chk(ack, 8'h00, "rd_ack");
      for (k = 0; k < n; k = k + 1) begin
        i_lcdrp_host_bfm.xfer(8'hff, k == n - 1, q, ack);
        chk(q, exp[k], "rd_data");
      end
      i_lcdrp_host_bfm.stop_cond;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(selected, 8'h00, "desel");
    end
  endtask
  task test_ctl;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        load(1'b0, k[7:0], 8'hff);
      end
      exp[0] = 8'he3;
      exp[1] = 8'he7;
      exp[2] = 8'h0f;
      exp[3] = 8'hc1;
      rd_seq(7'h38, 8'h00, 4);
      $display("test_ctl done");
    end
  endtask
  task test_seg;
    begin
      load(1'b1, 8'h26, 8'h5a);
      load(1'b1, 8'h27, 8'hff);
      load(1'b1, 8'h28, 8'hff);
      exp[0] = 8'h0a;
      exp[1] = 8'h0f;
      exp[2] = 8'h00;
      rd_seq(7'h39, 8'h26, 3);
      $display("test_seg done");
    end
  endtask
  task test_bad_id;
    reg [7:0] q;
    reg ack;
    begin
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({7'h3a, 1'b0}, 1'b1, q, ack);
      chk(ack, 8'h01, "bad_ack");
      chk(selected, 8'h00, "bad_sel");
      i_lcdrp_host_bfm.stop_cond;
      $display("test_bad_id done");
    end
  endtask
  task test_reset_mid;
    reg [7:0] q;
    reg ack;
    begin
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({7'h38, 1'b0}, 1'b1, q, ack);
      @(posedge clk_sys) #1;
      reset_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(sda_oe, 8'h00, "rst_sda");
      chk(selected, 8'h00, "rst_sel");
      reset_n = 1'b1;
      i_lcdrp_host_bfm.stop_cond;
      exp[0] = 8'h00;
      rd_seq(7'h38, 8'h01, 1);
      $display("test_reset_mid done");
    end
  endtask
  task test_refused;
    reg [7:0] q;
    reg ack;
    begin
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({7'h38, 1'b1}, 1'b1, q, ack);
      chk(ack, 8'h01, "rd_noadr");
      i_lcdrp_host_bfm.stop_cond;
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({7'h38, 1'b0}, 1'b1, q, ack);
      i_lcdrp_host_bfm.xfer(8'h00, 1'b1, q, ack);
      i_lcdrp_host_bfm.start_cond;
      i_lcdrp_host_bfm.xfer({7'h39, 1'b1}, 1'b1, q, ack);
      chk(ack, 8'h01, "rd_xblk");
      chk(selected, 8'h00, "xblk_sel");
      i_lcdrp_host_bfm.stop_cond;
      $display("test_refused done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  initial begin
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    load_en = 1'b0;
    load_block = 1'b0;
    load_addr = 8'h00;
    load_data = 8'h00;
    repeat (12) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    test_ctl;
    test_seg;
    test_bad_id;
    test_refused;
    test_reset_mid;
    report_and_stop;
  end
endmodule
